// *** tbct_pkg.sv ***
// Package: register map, field layout and codes of the ten-bit compare timer
package tbct_pkg;
   // Register byte addresses
   localparam logic [7:0] OFS_CTRL0   = 8'h00;
   localparam logic [7:0] OFS_CTRL1   = 8'h04;
   localparam logic [7:0] OFS_CNT_LO  = 8'h08;
   localparam logic [7:0] OFS_CNT_HI  = 8'h0C;
   localparam logic [7:0] OFS_CMPA_LO = 8'h10;
   localparam logic [7:0] OFS_CMPA_HI = 8'h14;
   // Control 0 fields
   localparam int CTRL0_PAUSE  = 7;
   localparam int CTRL0_CKS_HI = 6;
   localparam int CTRL0_CKS_LO = 4;
   localparam int CTRL0_ON     = 3;
   localparam int CTRL0_PRD_HI = 2;
   localparam int CTRL0_PRD_LO = 0;
   // Control 1 fields
   localparam int CTRL1_MODE_HI = 7;
   localparam int CTRL1_MODE_LO = 6;
   localparam int CTRL1_IO_HI   = 5;
   localparam int CTRL1_IO_LO   = 4;
   localparam int CTRL1_OC      = 3;
   localparam int CTRL1_POL     = 2;
   localparam int CTRL1_DPX     = 1;
   localparam int CTRL1_CCLR    = 0;
   // Reset values
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [9:0] CMPA_RST  = 10'h000;
   // Clock select codes
   localparam logic [2:0] CKS_SYS_DIV4  = 3'h0;
   localparam logic [2:0] CKS_SYS       = 3'h1;
   localparam logic [2:0] CKS_HIGH_DIV16 = 3'h2;
   localparam logic [2:0] CKS_HIGH_DIV64 = 3'h3;
   localparam logic [2:0] CKS_SUB_A     = 3'h4;
   localparam logic [2:0] CKS_SUB_B     = 3'h5;
   localparam logic [2:0] CKS_PIN_RISE  = 3'h6;
   localparam logic [2:0] CKS_PIN_FALL  = 3'h7;
   // Operating modes
   localparam logic [1:0] MODE_COMPARE = 2'h0;
   localparam logic [1:0] MODE_PWM     = 2'h2;
   localparam logic [1:0] MODE_TIMER   = 2'h3;
   // Output actions
   localparam logic [1:0] IO_NONE   = 2'h0;
   localparam logic [1:0] IO_LOW    = 2'h1;
   localparam logic [1:0] IO_HIGH   = 2'h2;
   localparam logic [1:0] IO_TOGGLE = 2'h3;
   localparam logic [1:0] IO_PWM_OFF = 2'h0;
   localparam logic [1:0] IO_PWM_ON  = 2'h1;
   localparam logic [1:0] IO_PWM_RUN = 2'h2;
   // Prescaler ratios
   localparam int DIV_4  = 4;
   localparam int DIV_16 = 16;
   localparam int DIV_64 = 64;
   // AXI responses
   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** tbct_edge_sync.sv ***
// Two-stage synchroniser with edge detection for an asynchronous pin
`timescale 1ns/100ps
module tbct_edge_sync (
   input  wire logic clk,
   input  wire logic nrst,
   input  wire logic pin,
   output logic      rise,
   output logic      fall
);
   typedef struct packed {
      logic meta;
      logic sync;
      logic last;
   } tbct_sync_t;

   tbct_sync_t s_reg;
   tbct_sync_t s_next;

   always_comb begin
      s_next      = s_reg;
      s_next.meta = pin;
      s_next.sync = s_reg.meta;
      s_next.last = s_reg.sync;
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   // Only the second stage and its delayed copy feed the edge logic
   assign rise = s_reg.sync & ~s_reg.last;
   assign fall = ~s_reg.sync & s_reg.last;
endmodule

// *** tbct_prescale.sv ***
// Free-running prescaler giving one-cycle ticks at /4, /16 and /64
`timescale 1ns/100ps
module tbct_prescale (
   input  wire logic clk,
   input  wire logic nrst,
   output logic      tick4,
   output logic      tick16,
   output logic      tick64
);
   typedef struct packed {
      logic [5:0] cnt;
      logic       t4;
      logic       t16;
      logic       t64;
   } tbct_pre_t;

   tbct_pre_t s_reg;
   tbct_pre_t s_next;

   always_comb begin
      s_next     = s_reg;
      s_next.cnt = s_reg.cnt + 6'h01;
      s_next.t4  = (s_reg.cnt[1:0] == 2'(tbct_pkg::DIV_4 - 1));
      s_next.t16 = (s_reg.cnt[3:0] == 4'(tbct_pkg::DIV_16 - 1));
      s_next.t64 = (s_reg.cnt == 6'(tbct_pkg::DIV_64 - 1));
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end

   assign tick4  = s_reg.t4;
   assign tick16 = s_reg.t16;
   assign tick64 = s_reg.t64;
endmodule

// *** tbct_timer.sv ***
// Ten-bit compare timer with AXI4-Lite register access
//
// Implementation choices: the address map and register access over AXI4-Lite.
`timescale 1ns/100ps
module tbct_timer #(
   parameter int ADDR_W = 8
) (
   input  wire logic              CLK_SYS,
   input  wire logic              NRST,
   input  wire logic [ADDR_W-1:0] AWADDR,
   input  wire logic              AWVALID,
   output logic                   AWREADY,
   input  wire logic [31:0]       WDATA,
   input  wire logic [3:0]        WSTRB,
   input  wire logic              WVALID,
   output logic                   WREADY,
   output logic [1:0]             BRESP,
   output logic                   BVALID,
   input  wire logic              BREADY,
   input  wire logic [ADDR_W-1:0] ARADDR,
   input  wire logic              ARVALID,
   output logic                   ARREADY,
   output logic [31:0]            RDATA,
   output logic [1:0]             RRESP,
   output logic                   RVALID,
   input  wire logic              RREADY,
   input  wire logic              EXT_COUNT_CLOCK_PIN,
   input  wire logic              SUB_CLOCK_PIN,
   output logic                   TIMER_OUTPUT_PIN,
   output logic                   TIMER_OUTPUT_INVERTED_PIN,
   output logic                   COMPARE_A_MATCH,
   output logic                   COMPARE_P_MATCH
);
   // Fewer bits lose the top registers; more would be cut by the byte decode
   if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr_w
      $error("ADDR_W must be 5 to 8");
   end

   typedef struct packed {
      logic       aw_have;
      logic [7:0] aw_addr;
      logic       w_have;
      logic [7:0] w_data;
      logic       w_strb0;
      logic       awready;
      logic       wready;
      logic       bvalid;
      logic [1:0] bresp;
      logic       arready;
      logic       rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic [7:0] ctrl0;
      logic [7:0] ctrl1;
      logic [9:0] compare_a_value;
      logic [7:0] byte_buffer;
      logic [9:0] count;
      logic       on_last;
      logic       out_lvl;
      logic       match_a;
      logic       match_p;
      logic       pin;
      logic       pin_b;
   } tbct_state_t;

   tbct_state_t s_reg;
   tbct_state_t s_next;

   logic tick4;
   logic tick16;
   logic tick64;
   logic ext_rise;
   logic ext_fall;
   logic sub_rise;

   tbct_prescale u_pre (
      .clk    (CLK_SYS),
      .nrst   (NRST),
      .tick4  (tick4),
      .tick16 (tick16),
      .tick64 (tick64)
   );

   tbct_edge_sync u_ext (
      .clk  (CLK_SYS),
      .nrst (NRST),
      .pin  (EXT_COUNT_CLOCK_PIN),
      .rise (ext_rise),
      .fall (ext_fall)
   );

   tbct_edge_sync u_sub (
      .clk  (CLK_SYS),
      .nrst (NRST),
      .pin  (SUB_CLOCK_PIN),
      .rise (sub_rise),
      .fall ()
   );

   // Register index decode, shared by read and write paths
   function automatic logic is_reg(input logic [7:0] a, input logic [7:0] ofs);
      is_reg = (a[7:2] == ofs[7:2]);
   endfunction

   function automatic logic is_mapped(input logic [7:0] a);
      is_mapped = is_reg(a, tbct_pkg::OFS_CTRL0) | is_reg(a, tbct_pkg::OFS_CTRL1)
                | is_reg(a, tbct_pkg::OFS_CNT_LO) | is_reg(a, tbct_pkg::OFS_CNT_HI)
                | is_reg(a, tbct_pkg::OFS_CMPA_LO) | is_reg(a, tbct_pkg::OFS_CMPA_HI);
   endfunction

   logic [2:0] cks;
   logic [1:0] mode;
   logic [1:0] io_sel;
   logic [2:0] period_sel;
   logic       oc;
   logic       pol;
   logic       dpx;
   logic       cclr;
   logic       on_now;
   logic       pause;

   assign cks        = s_reg.ctrl0[tbct_pkg::CTRL0_CKS_HI:tbct_pkg::CTRL0_CKS_LO];
   assign on_now     = s_reg.ctrl0[tbct_pkg::CTRL0_ON];
   assign pause      = s_reg.ctrl0[tbct_pkg::CTRL0_PAUSE];
   assign period_sel = s_reg.ctrl0[tbct_pkg::CTRL0_PRD_HI:tbct_pkg::CTRL0_PRD_LO];
   assign mode       = s_reg.ctrl1[tbct_pkg::CTRL1_MODE_HI:tbct_pkg::CTRL1_MODE_LO];
   assign io_sel     = s_reg.ctrl1[tbct_pkg::CTRL1_IO_HI:tbct_pkg::CTRL1_IO_LO];
   assign oc         = s_reg.ctrl1[tbct_pkg::CTRL1_OC];
   assign pol        = s_reg.ctrl1[tbct_pkg::CTRL1_POL];
   assign dpx        = s_reg.ctrl1[tbct_pkg::CTRL1_DPX];
   assign cclr       = s_reg.ctrl1[tbct_pkg::CTRL1_CCLR];

   // Counting clock selection
   logic cnt_tick;

   always_comb begin
      case (cks)
         tbct_pkg::CKS_SYS_DIV4:   cnt_tick = tick4;
         tbct_pkg::CKS_SYS:        cnt_tick = 1'b1;
         tbct_pkg::CKS_HIGH_DIV16: cnt_tick = tick16;
         tbct_pkg::CKS_HIGH_DIV64: cnt_tick = tick64;
         tbct_pkg::CKS_SUB_A:      cnt_tick = sub_rise;
         tbct_pkg::CKS_SUB_B:      cnt_tick = sub_rise;
         tbct_pkg::CKS_PIN_RISE:   cnt_tick = ext_rise;
         tbct_pkg::CKS_PIN_FALL:   cnt_tick = ext_fall;
         default:                  cnt_tick = 1'b0;
      endcase
   end

   // Match detection on the value the counter is about to reach
   logic [9:0] cnt_inc;
   logic       hit_a;
   logic       hit_p;
   logic       clr_on_a;
   logic       pwm_active;

   assign cnt_inc = s_reg.count + 10'h001;
   assign hit_a   = (cnt_inc == s_reg.compare_a_value);
   // Code zero waits for the wrap, giving the full 1024-clock period
   assign hit_p   = (cnt_inc[9:7] == period_sel) && (cnt_inc[6:0] == 7'h00);
   // PWM fixes the clear source by the duty/period split
   assign clr_on_a = (mode == tbct_pkg::MODE_PWM) ? dpx : cclr;
   // Active part runs from the counter start to the duty match
   assign pwm_active = dpx ? (s_reg.count[9:7] < period_sel)
                           : (s_reg.count < s_reg.compare_a_value);

   logic       wr_go;
   logic       rd_go;
   logic [7:0] ar8;
   logic       cnt_run;

   assign wr_go = s_reg.aw_have && s_reg.w_have && !s_reg.bvalid;
   assign rd_go = ARVALID && s_reg.arready;
   assign ar8   = 8'(ARADDR);
   // Pause freezes count and matches; the output level holds meanwhile
   assign cnt_run = on_now && !pause && cnt_tick;

   always_comb begin
      s_next = s_reg;
      s_next.match_a = 1'b0;
      s_next.match_p = 1'b0;

      // Write channel capture, address and data in either order
      if (AWVALID && s_reg.awready) begin
         s_next.aw_have = 1'b1;
         s_next.aw_addr = 8'(AWADDR);
      end
      if (WVALID && s_reg.wready) begin
         s_next.w_have  = 1'b1;
         s_next.w_data  = WDATA[7:0];
         s_next.w_strb0 = WSTRB[0];
      end
      if (s_reg.bvalid && BREADY) begin
         s_next.bvalid = 1'b0;
      end

      if (wr_go) begin
         s_next.aw_have = 1'b0;
         s_next.w_have  = 1'b0;
         s_next.bvalid  = 1'b1;
         s_next.bresp   = is_mapped(s_reg.aw_addr) ? tbct_pkg::RESP_OKAY
                                                   : tbct_pkg::RESP_SLVERR;
         // Counter registers ignore writes; there is no load path
         if (s_reg.w_strb0) begin
            if (is_reg(s_reg.aw_addr, tbct_pkg::OFS_CTRL0)) begin
               s_next.ctrl0 = s_reg.w_data;
            end
            if (is_reg(s_reg.aw_addr, tbct_pkg::OFS_CTRL1)) begin
               s_next.ctrl1 = s_reg.w_data;
            end
            if (is_reg(s_reg.aw_addr, tbct_pkg::OFS_CMPA_LO)) begin
               s_next.byte_buffer = s_reg.w_data;
            end
            if (is_reg(s_reg.aw_addr, tbct_pkg::OFS_CMPA_HI)) begin
               s_next.compare_a_value = {s_reg.w_data[1:0], s_reg.byte_buffer};
            end
         end
      end

      // Read channel; a read capture lands after any same-cycle write
      if (s_reg.rvalid && RREADY) begin
         s_next.rvalid = 1'b0;
      end
      if (rd_go) begin
         s_next.rvalid = 1'b1;
         s_next.rresp  = is_mapped(ar8) ? tbct_pkg::RESP_OKAY : tbct_pkg::RESP_SLVERR;
         s_next.rdata  = 8'h00;
         if (is_reg(ar8, tbct_pkg::OFS_CTRL0)) begin
            s_next.rdata = s_reg.ctrl0;
         end
         if (is_reg(ar8, tbct_pkg::OFS_CTRL1)) begin
            s_next.rdata = s_reg.ctrl1;
         end
         if (is_reg(ar8, tbct_pkg::OFS_CNT_LO) || is_reg(ar8, tbct_pkg::OFS_CMPA_LO)) begin
            s_next.rdata = s_reg.byte_buffer;
         end
         if (is_reg(ar8, tbct_pkg::OFS_CNT_HI)) begin
            s_next.rdata       = {6'h00, s_reg.count[9:8]};
            s_next.byte_buffer = s_reg.count[7:0];
         end
         if (is_reg(ar8, tbct_pkg::OFS_CMPA_HI)) begin
            s_next.rdata       = {6'h00, s_reg.compare_a_value[9:8]};
            s_next.byte_buffer = s_reg.compare_a_value[7:0];
         end
      end

      s_next.awready = !s_next.aw_have && !s_next.bvalid;
      s_next.wready  = !s_next.w_have && !s_next.bvalid;
      s_next.arready = !s_next.rvalid;

      // Counter core
      s_next.on_last = on_now;
      if (on_now && !s_reg.on_last) begin
         s_next.count   = 10'h000;
         s_next.out_lvl = oc;
      end else if (cnt_run) begin
         s_next.match_a = hit_a;
         s_next.match_p = hit_p;
         if ((clr_on_a && hit_a) || (!clr_on_a && hit_p)) begin
            s_next.count = 10'h000;
         end else begin
            s_next.count = cnt_inc;
         end
         if (mode == tbct_pkg::MODE_COMPARE && hit_a) begin
            case (io_sel)
               tbct_pkg::IO_LOW:    s_next.out_lvl = 1'b0;
               tbct_pkg::IO_HIGH:   s_next.out_lvl = 1'b1;
               tbct_pkg::IO_TOGGLE: s_next.out_lvl = !s_reg.out_lvl;
               default:             s_next.out_lvl = s_reg.out_lvl;
            endcase
         end
      end

      if (mode == tbct_pkg::MODE_PWM && on_now) begin
         case (io_sel)
            tbct_pkg::IO_PWM_OFF: s_next.out_lvl = !oc;
            tbct_pkg::IO_PWM_ON:  s_next.out_lvl = oc;
            tbct_pkg::IO_PWM_RUN: s_next.out_lvl = pwm_active ? oc : !oc;
            default:              s_next.out_lvl = s_reg.out_lvl;
         endcase
      end

      // Polarity applies in compare and PWM modes only
      case (mode)
         tbct_pkg::MODE_COMPARE: s_next.pin = s_reg.out_lvl ^ pol;
         tbct_pkg::MODE_PWM:     s_next.pin = s_reg.out_lvl ^ pol;
         tbct_pkg::MODE_TIMER:   s_next.pin = s_reg.out_lvl;
         default:                s_next.pin = s_reg.out_lvl;
      endcase
      s_next.pin_b = !s_next.pin;
   end

   always_ff @(posedge CLK_SYS or negedge NRST) begin
      if (!NRST) begin
         s_reg                 <= '0;
         s_reg.ctrl0           <= tbct_pkg::CTRL0_RST;
         s_reg.ctrl1           <= tbct_pkg::CTRL1_RST;
         s_reg.compare_a_value <= tbct_pkg::CMPA_RST;
         s_reg.pin_b           <= 1'b1;
      end else begin
         s_reg <= s_next;
      end
   end

   assign AWREADY                   = s_reg.awready;
   assign WREADY                    = s_reg.wready;
   assign BVALID                    = s_reg.bvalid;
   assign BRESP                     = s_reg.bresp;
   assign ARREADY                   = s_reg.arready;
   assign RVALID                    = s_reg.rvalid;
   assign RRESP                     = s_reg.rresp;
   assign RDATA                     = {24'h000000, s_reg.rdata};
   assign TIMER_OUTPUT_PIN          = s_reg.pin;
   assign TIMER_OUTPUT_INVERTED_PIN = s_reg.pin_b;
   assign COMPARE_A_MATCH           = s_reg.match_a;
   assign COMPARE_P_MATCH           = s_reg.match_p;
endmodule

// *** tbct_timer_assertions.sv ***
// Checker of bus handshakes, match pulses and output pins of the compare timer
`timescale 1ns/100ps
module tbct_timer_assertions #(
   parameter int ADDR_W = 8
) (
   input wire logic              CLK_SYS,
   input wire logic              NRST,
   input wire logic [ADDR_W-1:0] AWADDR,
   input wire logic              AWVALID,
   input wire logic              AWREADY,
   input wire logic [31:0]       WDATA,
   input wire logic [3:0]        WSTRB,
   input wire logic              WVALID,
   input wire logic              WREADY,
   input wire logic [1:0]        BRESP,
   input wire logic              BVALID,
   input wire logic              BREADY,
   input wire logic [ADDR_W-1:0] ARADDR,
   input wire logic              ARVALID,
   input wire logic              ARREADY,
   input wire logic [31:0]       RDATA,
   input wire logic [1:0]        RRESP,
   input wire logic              RVALID,
   input wire logic              RREADY,
   input wire logic              EXT_COUNT_CLOCK_PIN,
   input wire logic              SUB_CLOCK_PIN,
   input wire logic              TIMER_OUTPUT_PIN,
   input wire logic              TIMER_OUTPUT_INVERTED_PIN,
   input wire logic              COMPARE_A_MATCH,
   input wire logic              COMPARE_P_MATCH
);
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!NRST);
   property p_inv; TIMER_OUTPUT_INVERTED_PIN == !TIMER_OUTPUT_PIN; endproperty
   a_inv: assert property (p_inv) else $error("inverted pin not inverse");
   property p_bhold; BVALID && !BREADY |=> BVALID && $stable(BRESP); endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped");
   property p_rhold;
      RVALID && !RREADY |=> RVALID && $stable(RDATA) && $stable(RRESP);
   endproperty
   a_rhold: assert property (p_rhold) else $error("read data dropped");
   property p_rhi; RVALID |-> RDATA[31:8] == 24'h0; endproperty
   a_rhi: assert property (p_rhi) else $error("read data upper bits set");
   property p_rans; ARVALID && ARREADY |=> RVALID; endproperty
   a_rans: assert property (p_rans) else $error("read answer late");
   property p_bans; AWVALID && AWREADY && WVALID && WREADY |-> ##[1:2] BVALID; endproperty
   a_bans: assert property (p_bans) else $error("write answer late");
   property p_slverr;
      ARVALID && ARREADY && ARADDR[7:2] > 6'h05 |=>
         RRESP == tbct_pkg::RESP_SLVERR && RDATA == 32'h0;
   endproperty
   a_slverr: assert property (p_slverr) else $error("unmapped read accepted");
   property p_arrdy; RVALID |-> !ARREADY; endproperty
   a_arrdy: assert property (p_arrdy) else $error("second read taken");
   property p_p1; COMPARE_P_MATCH |=> !COMPARE_P_MATCH; endproperty
   a_p1: assert property (p_p1) else $error("period match too close");
   c_p: cover property (COMPARE_P_MATCH);
   c_a: cover property (COMPARE_A_MATCH);
   c_err: cover property (RVALID && RRESP == tbct_pkg::RESP_SLVERR);
endmodule

bind tbct_timer tbct_timer_assertions #(.ADDR_W(ADDR_W)) tbct_timer_assertions_i (
   .CLK_SYS(CLK_SYS), .NRST(NRST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
   .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
   .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
   .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
   .EXT_COUNT_CLOCK_PIN(EXT_COUNT_CLOCK_PIN), .SUB_CLOCK_PIN(SUB_CLOCK_PIN),
   .TIMER_OUTPUT_PIN(TIMER_OUTPUT_PIN),
   .TIMER_OUTPUT_INVERTED_PIN(TIMER_OUTPUT_INVERTED_PIN),
   .COMPARE_A_MATCH(COMPARE_A_MATCH), .COMPARE_P_MATCH(COMPARE_P_MATCH));

// *** tbct_pins_model.sv ***
// Pin-side partner: external count clock bursts and a free-running sub clock
`timescale 1ns/100ps
module tbct_pins_model #(
   parameter int SUB_HALF_NS = 1600
) (
   output logic ext_pin,
   output logic sub_pin
);
   // Sub oscillator runs free; each edge falls on a falling edge of the bench system clock
   initial begin
      ext_pin = 1'b0;
      sub_pin = 1'b0;
      forever #(SUB_HALF_NS) sub_pin = ~sub_pin;
   end
   // Whole pulses only; the pin stands low between bursts
   task automatic burst(input int n, input int half_ns);
      repeat (n) begin
         #(half_ns) ext_pin = 1'b1;
         #(half_ns) ext_pin = 1'b0;
      end
   endtask
endmodule

// *** test_ten_bit_compare_timer.sv ***
// Self-checking bench of the ten-bit compare timer
`timescale 1ns/100ps
module test_ten_bit_compare_timer;
   logic        clk_sys, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
   logic        arvalid, arready, rvalid, rready, ext_pin, sub_pin, out_pin, out_n, ma, mp;
   logic        oc, ex;
   logic [7:0]  awaddr, araddr, c0;
   logic [31:0] wdata, rdata;
   logic [3:0]  wstrb;
   logic [1:0]  bresp, rresp;
   logic [33:0] e;
   logic [33:0] rq[$];
   logic [1:0]  wq[$];
   int          failures, n_checks, cyc, a_last, a_exp, a_hits, p_last, p_exp, p_hits;
   int          i, v, seed_v, ha, hp, hi;
   int          cks_iv[6] = '{32, 8, 128, 512, 256, 256};

   tbct_timer tbct_timer_i (
      .CLK_SYS(clk_sys), .NRST(nrst), .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
      .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready), .BRESP(bresp),
      .BVALID(bvalid), .BREADY(bready), .ARADDR(araddr), .ARVALID(arvalid),
      .ARREADY(arready), .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
      .EXT_COUNT_CLOCK_PIN(ext_pin), .SUB_CLOCK_PIN(sub_pin), .TIMER_OUTPUT_PIN(out_pin),
      .TIMER_OUTPUT_INVERTED_PIN(out_n), .COMPARE_A_MATCH(ma), .COMPARE_P_MATCH(mp));
   tbct_pins_model tbct_pins_model_i (.ext_pin(ext_pin), .sub_pin(sub_pin));

   initial begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end

   task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, exp, seen);
      end
   endtask

   task automatic end_of_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     input logic [1:0] r = tbct_pkg::RESP_OKAY);
      bit ad, wd;
      ad = 1'b0;
      wd = 1'b0;
      wq.push_back(r);
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (!(ad && wd)) begin
         @(posedge clk_sys);
         if (!ad && awready) begin
            awvalid <= 1'b0;
            ad = 1'b1;
         end
         if (!wd && wready) begin
            wvalid <= 1'b0;
            wd = 1'b1;
         end
      end
      do @(posedge clk_sys); while (!bvalid);
      bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r = tbct_pkg::RESP_OKAY);
      rq.push_back({r, d});
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do @(posedge clk_sys); while (!arready);
      arvalid <= 1'b0;
      do @(posedge clk_sys); while (!rvalid);
      rready <= 1'b0;
   endtask

   // Restart from off so the on-bit edge clears the counter; low byte before high
   task automatic run(input logic [7:0] c1, input logic [9:0] m, input logic [7:0] c,
                      input int ae, input int pe);
      wr(tbct_pkg::OFS_CTRL0, 8'h00);
      wr(tbct_pkg::OFS_CTRL1, c1);
      wr(tbct_pkg::OFS_CMPA_LO, m[7:0]);
      wr(tbct_pkg::OFS_CMPA_HI, {6'h0, m[9:8]});
      a_last = 0;
      p_last = 0;
      a_exp = ae;
      p_exp = pe;
      ha = a_hits;
      hp = p_hits;
      wr(tbct_pkg::OFS_CTRL0, c);
   endtask

   task automatic wait_n(input int n, input bit p);
      for (int k = 0; k < 9000 && (p ? p_hits - hp : a_hits - ha) < n; k++) @(posedge clk_sys);
      check("match_count", p ? p_hits - hp : a_hits - ha, n);
   endtask

   always @(posedge clk_sys) begin
      cyc++;
      if (rvalid && rready) begin
         e = rq.pop_front();
         check("rdata", rdata, e[31:0]);
         check("rresp", {30'h0, rresp}, {30'h0, e[33:32]});
      end
      if (bvalid && bready) check("bresp", {30'h0, bresp}, {30'h0, wq.pop_front()});
      if (ma === 1'b1) begin
         a_hits++;
         if (a_exp != 0 && a_last != 0) check("a_period", cyc - a_last, a_exp);
         a_last = cyc;
      end
      if (mp === 1'b1) begin
         p_hits++;
         if (p_exp != 0 && p_last != 0) check("p_period", cyc - p_last, p_exp);
         p_last = cyc;
      end
   end

   initial begin
      nrst = 1'b0;
      {awaddr, araddr, wdata, awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hF;
      seed_v = $urandom(54053);
      repeat (3) @(posedge clk_sys);
      nrst <= 1'b1;
      for (i = 0; i < 6; i++) rd(8'(i * 4), 32'h0);
      rd(8'h18, 32'h0, tbct_pkg::RESP_SLVERR);
      rd(8'hFC, 32'h0, tbct_pkg::RESP_SLVERR);
      wr(8'h20, 8'h5A, tbct_pkg::RESP_SLVERR);
      wstrb <= 4'h0;
      wr(tbct_pkg::OFS_CTRL1, 8'hFF);
      wstrb <= 4'hF;
      rd(tbct_pkg::OFS_CTRL1, 32'h0);
      v = $urandom_range(1023, 16);
      wr(tbct_pkg::OFS_CMPA_LO, v[7:0]);
      rd(tbct_pkg::OFS_CMPA_HI, 32'h0);
      rd(tbct_pkg::OFS_CMPA_LO, 32'h0);
      wr(tbct_pkg::OFS_CMPA_LO, v[7:0]);
      wr(tbct_pkg::OFS_CMPA_HI, {6'h0, v[9:8]});
      rd(tbct_pkg::OFS_CMPA_HI, {30'h0, v[9:8]});
      rd(tbct_pkg::OFS_CMPA_LO, {24'h0, v[7:0]});
      wr(tbct_pkg::OFS_CMPA_LO, ~v[7:0]);
      rd(tbct_pkg::OFS_CMPA_LO, {24'h0, ~v[7:0]});
      rd(tbct_pkg::OFS_CMPA_HI, {30'h0, v[9:8]});
      rd(tbct_pkg::OFS_CMPA_LO, {24'h0, v[7:0]});
      for (i = 0; i < 8; i++) begin
         run(8'h00, 10'h3FF, {1'b0, tbct_pkg::CKS_SYS, 1'b1, 3'(i)}, 0, i ? i * 128 : 1024);
         wait_n(3, 1);
      end
      for (i = 0; i < 6; i++) begin
         run(8'hC1, 10'h008, {1'b0, 3'(i), 1'b1, 3'h0}, cks_iv[i], 0);
         wait_n(3, 0);
      end
      for (i = 0; i < 2; i++) begin
         c0 = {1'b0, i ? tbct_pkg::CKS_PIN_FALL : tbct_pkg::CKS_PIN_RISE, 1'b1, 3'h0};
         run({tbct_pkg::MODE_TIMER, 6'h01}, 10'h005, c0, 0, 0);
         tbct_pins_model_i.burst(5, 330);
         repeat (5) @(posedge clk_sys);
         check("ext_hits", a_hits - ha, 1);
         tbct_pins_model_i.burst(3, 730);
         repeat (5) @(posedge clk_sys);
         rd(tbct_pkg::OFS_CNT_HI, 32'h0);
         rd(tbct_pkg::OFS_CNT_LO, 32'h3);
         wr(tbct_pkg::OFS_CTRL0, c0 | 8'(1 << tbct_pkg::CTRL0_PAUSE));
         tbct_pins_model_i.burst(2, 730);
         repeat (5) @(posedge clk_sys);
         rd(tbct_pkg::OFS_CNT_HI, 32'h0);
         rd(tbct_pkg::OFS_CNT_LO, 32'h3);
         wr(tbct_pkg::OFS_CTRL0, 8'h00);
         wr(tbct_pkg::OFS_CTRL0, c0);
         wr(tbct_pkg::OFS_CNT_LO, 8'h77);
         wr(tbct_pkg::OFS_CNT_HI, 8'h03);
         rd(tbct_pkg::OFS_CNT_HI, 32'h0);
         rd(tbct_pkg::OFS_CNT_LO, 32'h0);
      end
      // Output actions none, low, high, toggle; initial level opposite to the target for low, high and toggle
      for (i = 0; i < 4; i++) begin
         oc = (i == 2) ? 1'b0 : 1'b1;
         run({tbct_pkg::MODE_COMPARE, 2'(i), oc, 3'b001}, v[9:0],
             {1'b0, tbct_pkg::CKS_SYS, 1'b1, 3'h0}, v, 0);
         repeat (4) @(posedge clk_sys);
         check("pin_init", {31'h0, out_pin}, {31'h0, oc});
         wait_n(3, 0);
         repeat (v / 2) @(posedge clk_sys);
         ex = (i == 0) ? oc : (i == 1) ? 1'b0 : (i == 2) ? 1'b1 : ~oc;
         check("pin", {31'h0, out_pin}, {31'h0, ex});
         check("pin_n", {31'h0, out_n}, {31'h0, ~ex});
      end
      // Duty by compare A, period by compare A, inverted, forced active
      for (i = 0; i < 4; i++) begin
         c0 = {tbct_pkg::MODE_PWM, (i == 3) ? tbct_pkg::IO_PWM_ON : tbct_pkg::IO_PWM_RUN,
               1'b1, i == 2, i == 1, 1'b0};
         run(c0, (i == 1) ? 10'h200 : 10'h020, {1'b0, tbct_pkg::CKS_SYS, 1'b1, 3'h1},
             (i == 1) ? 512 : 0, (i == 1) ? 0 : 128);
         wait_n(2, i != 1);
         hi = 0;
         repeat (512) begin
            @(posedge clk_sys);
            hi += (out_pin === 1'b1);
         end
         check("pwm_high", hi, (i == 2) ? 384 : (i == 3) ? 512 : 128);
      end
      end_of_test();
   end

   initial begin
      #8000000;
      failures++;
      end_of_test();
   end
endmodule
